// File: hw/wwd_core.sv
// Window watchdog core: kick window checking and fault output timing
`include "wwd_regs.svh"
module wwd_core
	import wwd_pkg::*;
#(
	parameter int TICK_CYC  = `WWD_TICK_CYC,
	// [R10] Default lower bound
	parameter int WIN_LO_MS = `WWD_WIN_LO_MS,
	parameter int WIN_HI_MS = `WWD_WIN_HI_MS,
	parameter int HOLD_MS   = `WWD_HOLD_MS,
	parameter int CW        = `WWD_CNT_W
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic watchdog_enable_select,
	input  wire logic kick_input,
	input  wire logic reset_out_n,
	output logic      watchdog_fault_out_o,
	output logic      watchdog_fault_out_oe,
	output logic      watchdog_active
);
	typedef struct packed {
		wwd_state_t    st;
		logic [CW-1:0] cnt;
		logic          kick_prev;
		logic          fault_oe;
	} wwd_core_st_t;

	wwd_core_st_t s_r;
	wwd_core_st_t s_nxt;
	logic         tick;
	logic         kick_fall;
	logic         enabled;
	// Restarts the divider on the same edge as the window
	logic         tick_clr;

	generate
		if (WIN_LO_MS < 1 || WIN_HI_MS <= WIN_LO_MS || HOLD_MS < 1 || WIN_HI_MS >= (2 ** CW)
		    || HOLD_MS >= (2 ** CW)) begin : g_chk
			$error("wwd_core: window or hold values not served by CW");
		end
	endgenerate

	wwd_tick #(
		.DIV (TICK_CYC),
		.W   (`WWD_TICK_W)
	) u_tick (
		.clk     (clk),
		.reset_n (reset_n),
		.clr     (tick_clr),
		.tick    (tick)
	);

	assign kick_fall = s_r.kick_prev & ~kick_input;
	assign enabled   = watchdog_enable_select & reset_out_n;

	always_comb begin
		s_nxt           = s_r;
		tick_clr        = 1'b0;
		s_nxt.kick_prev = kick_input;
		if (!watchdog_enable_select || !reset_out_n) begin
			// [R1] [R3] [R4] [R9] Disable, ignore kicks
			s_nxt.st       = WWD_DIS;
			s_nxt.fault_oe = 1'b0;
			s_nxt.cnt      = '0;
			tick_clr       = 1'b1;
		end else begin
			// [R7] Only with reset high
			unique case (s_r.st)
				WWD_DIS: begin
					s_nxt.st  = WWD_OPEN;
					s_nxt.cnt = '0;
					tick_clr  = 1'b1;
				end
				WWD_OPEN: begin
					if (kick_fall) begin
						s_nxt.cnt = '0;
						tick_clr  = 1'b1;
						// [R6] Early kick faults
						if (s_r.cnt < CW'(WIN_LO_MS)) begin
							s_nxt.st       = WWD_FAULT;
							s_nxt.fault_oe = 1'b1;
						end
					end else if (tick) begin
						// [R6] Missing kick faults
						if (s_r.cnt == CW'(WIN_HI_MS - 1)) begin
							s_nxt.st       = WWD_FAULT;
							s_nxt.fault_oe = 1'b1;
							s_nxt.cnt      = '0;
						end else begin
							s_nxt.cnt = s_r.cnt + CW'(1);
						end
					end
				end
				WWD_FAULT: begin
					// [R3] Kicks ignored here
					if (tick) begin
						// [R8] Hold then release
						if (s_r.cnt == CW'(HOLD_MS - 1)) begin
							s_nxt.st       = WWD_OPEN;
							s_nxt.fault_oe = 1'b0;
							s_nxt.cnt      = '0;
						end else begin
							s_nxt.cnt = s_r.cnt + CW'(1);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r           <= '0;
			s_r.st        <= WWD_DIS;
			s_r.kick_prev <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// [R12] Drive-low only
	assign watchdog_fault_out_o  = 1'b0;
	assign watchdog_fault_out_oe = s_r.fault_oe;
	assign watchdog_active       = (s_r.st != WWD_DIS);

	sequence s_valid_kick;
		s_r.st == WWD_OPEN && enabled && kick_fall && s_r.cnt >= CW'(WIN_LO_MS);
	endsequence

	sequence s_early_kick;
		s_r.st == WWD_OPEN && enabled && kick_fall && s_r.cnt < CW'(WIN_LO_MS);
	endsequence

	property p_disabled_released;
		@(posedge clk) disable iff (!reset_n)
		!watchdog_enable_select |=> !watchdog_fault_out_oe && !watchdog_active;
	endproperty
	a_disabled_released: assert property (p_disabled_released) else $error("fault not released when disabled"); // [R1]

	property p_disabled_kick;
		@(posedge clk) disable iff (!reset_n)
		!watchdog_enable_select && kick_fall |=> s_r.st == WWD_DIS && s_r.cnt == '0;
	endproperty
	a_disabled_kick: assert property (p_disabled_kick) else $error("kick acted while disabled"); // [R4]

	property p_valid_kick;
		@(posedge clk) disable iff (!reset_n)
		s_valid_kick |=> s_r.cnt == '0 && !watchdog_fault_out_oe && s_r.st == WWD_OPEN;
	endproperty
	a_valid_kick: assert property (p_valid_kick) else $error("in-window kick did not restart"); // [R2]

	property p_early_kick;
		@(posedge clk) disable iff (!reset_n)
		s_early_kick |=> watchdog_fault_out_oe;
	endproperty
	a_early_kick: assert property (p_early_kick) else $error("early kick did not fault"); // [R6]

	property p_timeout;
		@(posedge clk) disable iff (!reset_n)
		s_r.st == WWD_OPEN && enabled && !kick_fall && tick && s_r.cnt == CW'(WIN_HI_MS - 1)
		|=> watchdog_fault_out_oe;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not fault"); // [R6]

	property p_assert_needs_reset_high;
		@(posedge clk) disable iff (!reset_n)
		$rose(watchdog_fault_out_oe) |-> $past(reset_out_n);
	endproperty
	a_assert_needs_reset_high: assert property (p_assert_needs_reset_high) else $error("fault rose under reset"); // [R7]

	property p_reset_releases;
		@(posedge clk) disable iff (!reset_n)
		!reset_out_n |=> !watchdog_fault_out_oe;
	endproperty
	a_reset_releases: assert property (p_reset_releases) else $error("fault held under reset"); // [R9]

	property p_ignore_in_fault;
		@(posedge clk) disable iff (!reset_n)
		watchdog_fault_out_oe && enabled && kick_fall && !tick |=> watchdog_fault_out_oe;
	endproperty
	a_ignore_in_fault: assert property (p_ignore_in_fault) else $error("kick acted during fault"); // [R3]

	property p_hold_len;
		@(posedge clk) disable iff (!reset_n)
		$fell(watchdog_fault_out_oe) && $past(enabled)
		|-> $past(tick) && $past(s_r.cnt) == CW'(HOLD_MS - 1);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("fault hold length wrong"); // [R8]

	property p_open_drain;
		@(posedge clk) disable iff (!reset_n)
		watchdog_fault_out_oe |-> !watchdog_fault_out_o ##1 !watchdog_fault_out_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("output driven high"); // [R12]
endmodule

// File: hw/wwd_pkg.sv
// Types of the window watchdog
package wwd_pkg;
	typedef enum logic [1:0] {
		WWD_DIS,
		WWD_OPEN,
		WWD_FAULT
	} wwd_state_t;
endpackage

// File: hw/wwd_regs.svh
// Timing constants of the window watchdog
// Overview of operation
// [R1] Select low disables the watchdog entirely
// [R2] Processor kicks falling edge inside window
// [R3] Kicks ignored while reset or fault low
// [R4] Kicks ignored while watchdog disabled
// [R5] Processor holds kick level defined when disabled
// [R6] Timeout or misplaced kick asserts fault low
// [R7] Fault asserts only while reset output high
// [R8] Fault held exactly the hold time, released
// [R9] Reset output low releases the fault
// [R10] Default lower window bound is 800 ms
// [R11] Select changes held at least 1 us
// [R12] Open-drain output modelled as drive-low enable
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH
`define WWD_CLK_PERIOD_NS   5
`define WWD_TICK_NS         1000000
`define WWD_TICK_CYC        (`WWD_TICK_NS / `WWD_CLK_PERIOD_NS)
`define WWD_WIN_LO_MS       800
`define WWD_WIN_HI_MS       1600
`define WWD_HOLD_MS         200
`define WWD_CNT_W           16
`define WWD_TICK_W          18
`endif

// File: hw/wwd_tick.sv
// Millisecond time base: one-cycle enable pulse from a divider
`include "wwd_regs.svh"
module wwd_tick #(
	parameter int DIV = `WWD_TICK_CYC,
	parameter int W   = `WWD_TICK_W
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic clr,
	output logic      tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} wwd_tick_st_t;

	wwd_tick_st_t s_r;
	wwd_tick_st_t s_nxt;

	generate
		if (DIV < 2 || DIV > (2 ** W)) begin : g_chk
			$error("wwd_tick: DIV out of range for W");
		end
	endgenerate

	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = 1'b0;
		if (clr) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt == W'(DIV - 1)) begin
			s_nxt.cnt  = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the window watchdog core
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 10;
	localparam int LO = 4;
	localparam int HI = 8;
	localparam int HD = 3;
	// Select level held 1 us at 5 ns
	localparam int SEL_HOLD = 200;
	logic        clk       = 1'b0;
	logic        reset_n   = 1'b0;
	logic        sel       = 1'b1;
	logic        rst_out_n = 1'b1;
	logic        kick;
	logic        f_oe;
	logic        act;
	logic        pad_o;
	logic [31:0] rng       = 32'hd457d12f;
	int          fails     = 0;
	int          num_checks = 0;
	int          exp_q[$];
	always #2.5 clk = ~clk;
	wwd_core #(.TICK_CYC(TC), .WIN_LO_MS(LO), .WIN_HI_MS(HI), .HOLD_MS(HD)) i_wwd_core (
		.clk(clk), .reset_n(reset_n), .watchdog_enable_select(sel), .kick_input(kick),
		.reset_out_n(rst_out_n), .watchdog_fault_out_o(pad_o), .watchdog_fault_out_oe(f_oe),
		.watchdog_active(act));
	wwd_proc_model i_wwd_proc_model (.clk(clk), .kick_input(kick));
	function automatic int xs(int m);
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return int'(rng % m);
	endfunction
	task automatic chk_int(string n, int e, int g, int tol);
		num_checks++;
		if (g < e - tol || g > e + tol) begin
			fails++;
			$display("ERROR %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic kick_at(int n);
		cyc(n);
		i_wwd_proc_model.kick();
	endtask
	task automatic end_of_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Scoreboard: fault length against oldest note, zero when cut short
	always begin
		int d;
		@(negedge clk iff f_oe === 1'b1);
		d = 0;
		do begin
			@(negedge clk);
			d++;
		end while (f_oe === 1'b1);
		if (!rst_out_n || !sel)
			d = 0;
		if (exp_q.size() == 0)
			chk_int("unexpected fault", -1, d, 0);
		else
			chk_int("fault hold cycles", exp_q.pop_front(), d, 1);
	end
	initial begin
		cyc(20000);
		fails++;
		end_of_test();
	end
	initial begin
		cyc(6);
		reset_n = 1'b1;
		exp_q.push_back(HD * TC);
		cyc(HI * TC - 5);
		chk_bit("fault before upper bound", 1'b0, f_oe);
		chk_bit("active when enabled", 1'b1, act);
		cyc(10);
		chk_bit("fault after upper bound", 1'b1, f_oe);
		chk_bit("fault pad level", 1'b0, pad_o);
		cyc(HD * TC + 5);
		$display("test timeout done");
		kick_at(LO * TC + 3);
		repeat (5) kick_at(LO * TC + xs(25));
		$display("test in window done");
		exp_q.push_back(HD * TC);
		kick_at(LO * TC - 14);
		kick_at(5);
		cyc(HD * TC);
		chk_bit("fault released", 1'b0, f_oe);
		$display("test early kick done");
		rst_out_n = 1'b0;
		repeat (6) kick_at(xs(30));
		cyc(HI * TC);
		chk_bit("fault while reset low", 1'b0, f_oe);
		chk_bit("active while reset low", 1'b0, act);
		rst_out_n = 1'b1;
		exp_q.push_back(0);
		cyc(HI * TC + 10);
		rst_out_n = 1'b0;
		cyc(2);
		chk_bit("fault cut by reset", 1'b0, f_oe);
		rst_out_n = 1'b1;
		$display("test reset output done");
		sel = 1'b0;
		cyc(SEL_HOLD);
		repeat (8) kick_at(xs(40));
		cyc(HI * TC);
		chk_bit("fault while disabled", 1'b0, f_oe);
		chk_bit("active while disabled", 1'b0, act);
		sel = 1'b1;
		kick_at(LO * TC + 3);
		kick_at(LO * TC + 2);
		cyc(HI * TC - 20);
		chk_bit("fault after enable", 1'b0, f_oe);
		chk_bit("active after enable", 1'b1, act);
		chk_int("pending faults", 0, exp_q.size(), 0);
		$display("test disable done");
		end_of_test();
	end
endmodule

// File: tb/wwd_proc_model.sv
// Processor model that issues watchdog kicks
module wwd_proc_model (
	input  wire logic clk,
	output logic      kick_input
);
	timeunit 1ns;
	timeprecision 1ps;
	initial kick_input = 1'b1;
	task automatic kick();
		@(negedge clk);
		kick_input = 1'b0;
		repeat (2) @(negedge clk);
		kick_input = 1'b1;
	endtask
endmodule
